// ### design/hpp_top.sv
// Host port pin logic with reset straps and AXI4-Lite register access
`timescale 1ns/10ps
// Notes on behaviour
// - Two select pins steer each host access to control, address or data.
// - Half-word pin marks first or second half; which half is high is configurable.
// - Direction pin chooses read (device drives data) or write (device takes data).
// - Sixteen-bit host bus carries control, address and data words.
// - Host bus levels set by pull resistors are sampled at reset for modes.
// - Bus line 8 at reset: low means big-endian, high means little-endian.
// - Bus lines 4:3 at reset: 00 host boot, 01/10/11 ROM 8/16/32 bit.
// - Device drives an interrupt output toward the host.
// - Device drives a ready output telling the host the access may complete.
module hpp_top (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic host_cs_n_i,
  input wire logic host_strobe_n_i,
  input wire logic host_reg_select_hi_i,
  input wire logic host_reg_select_lo_i,
  input wire logic host_halfword_order_i,
  input wire logic host_direction_i,
  input wire logic [15:0] host_bus_i,
  output logic [15:0] host_bus_o,
  output logic host_bus_oe_o,
  output logic host_irq_out_n_o,
  output logic host_access_ready_o,
  output hpp_pkg::hpp_strap_s strap_o,
  output logic irq_o,
  input wire logic [hpp_pkg::AXI_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [hpp_pkg::AXI_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  typedef enum logic {
    HPP_IDLE = 1'b0,
    HPP_ACCESS = 1'b1
  } hpp_state_e;

  hpp_pkg::hpp_pins_s pins_raw, pins;
  hpp_pkg::hpp_wr_s wr;
  logic rd_en;
  logic [31:0] rd_data;

  hpp_state_e state_q, state_d;
  hpp_pkg::hpp_sel_e sel_q, sel_d;
  logic second_q, second_d, dir_q, dir_d;
  logic [15:0] wlatch_q, wlatch_d;
  logic [15:0] bus_d;
  logic oe_d, ready_d, hirq_n_d, irq_d;
  logic first_high_q, first_high_d;
  logic host_irq_q, host_irq_d;
  logic [31:0] addr_q, addr_d, addr_stage_q, addr_stage_d;
  logic [31:0] wword_q, wword_d, wdata_q, wdata_d, rdata_q, rdata_d;
  logic wfull_q, wfull_d, rvalid_q, rvalid_d;
  logic [hpp_pkg::ST_W-1:0] status_q, status_d, mask_q, mask_d, ev;
  logic [1:0] strap_cnt_q, strap_cnt_d;
  logic strap_done_q, strap_done_d;
  hpp_pkg::hpp_strap_s strap_d;
  logic active;
  logic [31:0] wmask;
  logic [31:0] new_word;

  assign pins_raw = '{cs_n: host_cs_n_i, strobe_n: host_strobe_n_i,
                      sel: hpp_pkg::hpp_sel_e'({host_reg_select_hi_i, host_reg_select_lo_i}),
                      second: host_halfword_order_i, dir: host_direction_i, bus: host_bus_i};

  // Every pin passes two flops before any logic reads it
  hpp_sync #(
    .W($bits(hpp_pkg::hpp_pins_s)),
    .RST_VAL(hpp_pkg::PINS_IDLE)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(pins_raw),
    .q_o(pins)
  );

  hpp_axil u_axil (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i),
    .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i),
    .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i),
    .wr_o(wr),
    .rd_en_o(rd_en),
    .rd_data_i(rd_data)
  );

  assign active = !pins.cs_n && !pins.strobe_n;
  assign wmask = hpp_pkg::strb_mask(wr.strb);

  // Register read mux
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (s_axi_araddr_i)
      hpp_pkg::REG_STATUS: rd_data[hpp_pkg::ST_W-1:0] = status_q;
      hpp_pkg::REG_MASK: rd_data[hpp_pkg::ST_W-1:0] = mask_q;
      hpp_pkg::REG_STRAP: rd_data[2:0] = {strap_o.boot, strap_o.endian};
      hpp_pkg::REG_HADDR: rd_data = addr_q;
      hpp_pkg::REG_HWDATA: rd_data = wdata_q;
      hpp_pkg::REG_HRDATA: rd_data = rdata_q;
      hpp_pkg::REG_CTRL: begin
        rd_data[hpp_pkg::CR_IRQ_SET] = host_irq_q;
        rd_data[hpp_pkg::CR_FIRST_HIGH] = first_high_q;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Host access sequencing and register effects
  always_comb begin
    state_d = state_q;
    sel_d = sel_q;
    second_d = second_q;
    dir_d = dir_q;
    wlatch_d = wlatch_q;
    bus_d = host_bus_o;
    oe_d = host_bus_oe_o;
    ready_d = host_access_ready_o;
    first_high_d = first_high_q;
    host_irq_d = host_irq_q;
    addr_d = addr_q;
    addr_stage_d = addr_stage_q;
    wword_d = wword_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    wfull_d = wfull_q;
    rvalid_d = rvalid_q;
    ev = '0;
    new_word = 32'h0000_0000;
    unique case (state_q)
      HPP_IDLE: begin
        if (active) begin
          state_d = HPP_ACCESS;
          sel_d = pins.sel;
          second_d = pins.second;
          dir_d = pins.dir;
        end
      end
      HPP_ACCESS: begin
        if (!active) begin
          state_d = HPP_IDLE;
          if (dir_q != hpp_pkg::DIR_READ) begin
            unique case (sel_q)
              hpp_pkg::SEL_CTRL: begin
                first_high_d = wlatch_q[hpp_pkg::HC_FIRST_HIGH];
                ev[hpp_pkg::ST_DOORBELL] = wlatch_q[hpp_pkg::HC_DOORBELL];
                if (wlatch_q[hpp_pkg::HC_IRQ]) begin
                  host_irq_d = 1'b0;
                end
              end
              hpp_pkg::SEL_ADDR: begin
                new_word = hpp_pkg::put_half(addr_stage_q, wlatch_q, second_q, first_high_q);
                addr_stage_d = new_word;
                if (second_q) begin
                  addr_d = new_word;
                end
              end
              hpp_pkg::SEL_DATA_INC, hpp_pkg::SEL_DATA: begin
                new_word = hpp_pkg::put_half(wword_q, wlatch_q, second_q, first_high_q);
                wword_d = new_word;
                if (second_q && !wfull_q) begin
                  wdata_d = new_word;
                  wfull_d = 1'b1;
                  ev[hpp_pkg::ST_WDATA] = 1'b1;
                  if (sel_q == hpp_pkg::SEL_DATA_INC) begin
                    addr_d = addr_q + hpp_pkg::ADDR_STEP;
                  end
                end
              end
            endcase
          end else if (second_q && (sel_q == hpp_pkg::SEL_DATA_INC || sel_q == hpp_pkg::SEL_DATA)) begin
            rvalid_d = 1'b0;
            ev[hpp_pkg::ST_RDONE] = 1'b1;
            if (sel_q == hpp_pkg::SEL_DATA_INC) begin
              addr_d = addr_q + hpp_pkg::ADDR_STEP;
            end
          end
        end else if (dir_q != hpp_pkg::DIR_READ) begin
          wlatch_d = pins.bus;
        end
      end
    endcase
    // Output pins follow the access in flight
    oe_d = (state_d == HPP_ACCESS) && (dir_d == hpp_pkg::DIR_READ);
    unique case (sel_d)
      hpp_pkg::SEL_CTRL: bus_d = {13'h0, host_irq_q, 1'b0, first_high_q};
      hpp_pkg::SEL_ADDR: bus_d = hpp_pkg::pick_half(addr_q, second_d, first_high_q);
      hpp_pkg::SEL_DATA_INC, hpp_pkg::SEL_DATA: bus_d = hpp_pkg::pick_half(rdata_q, second_d, first_high_q);
    endcase
    if (!oe_d) begin
      bus_d = 16'h0000;
    end
    // Data accesses stall until a word is available or the slot is free
    ready_d = 1'b1;
    if (state_d == HPP_ACCESS && (sel_d == hpp_pkg::SEL_DATA_INC || sel_d == hpp_pkg::SEL_DATA)) begin
      ready_d = (dir_d == hpp_pkg::DIR_READ) ? rvalid_q : !(second_d && wfull_q);
    end
    // Software side effects; software wins over a same-cycle host event, except that a new host word keeps HWDATA full on its read
    if (rd_en && s_axi_araddr_i == hpp_pkg::REG_HWDATA) begin
      wfull_d = ev[hpp_pkg::ST_WDATA];
    end
    if (wr.en && wr.addr == hpp_pkg::REG_HRDATA) begin
      rdata_d = (rdata_q & ~wmask) | (wr.data & wmask);
      rvalid_d = 1'b1;
    end
    if (wr.en && wr.addr == hpp_pkg::REG_CTRL && wr.strb[0]) begin
      if (wr.data[hpp_pkg::CR_IRQ_SET]) begin
        host_irq_d = 1'b1;
      end
      first_high_d = wr.data[hpp_pkg::CR_FIRST_HIGH];
    end
  end

  // Sticky status, write one to clear, set wins
  always_comb begin
    status_d = status_q;
    mask_d = mask_q;
    if (wr.en && wr.addr == hpp_pkg::REG_STATUS && wr.strb[0]) begin
      status_d = status_q & ~wr.data[hpp_pkg::ST_W-1:0];
    end
    if (wr.en && wr.addr == hpp_pkg::REG_MASK && wr.strb[0]) begin
      mask_d = wr.data[hpp_pkg::ST_W-1:0];
    end
    status_d = status_d | ev;
    irq_d = |(status_d & mask_d);
    hirq_n_d = !host_irq_d;
  end

  // Strap capture once the synchroniser holds post-reset pin levels
  always_comb begin
    strap_cnt_d = strap_cnt_q;
    strap_done_d = strap_done_q;
    strap_d = strap_o;
    if (!strap_done_q) begin
      if (strap_cnt_q == hpp_pkg::STRAP_WAIT) begin
        strap_done_d = 1'b1;
        strap_d.endian = hpp_pkg::hpp_endian_e'(pins.bus[hpp_pkg::STRAP_ENDIAN_BIT]);
        strap_d.boot = hpp_pkg::hpp_boot_e'(pins.bus[hpp_pkg::STRAP_BOOT_HI:hpp_pkg::STRAP_BOOT_LO]);
      end else begin
        strap_cnt_d = strap_cnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= HPP_IDLE;
      sel_q <= hpp_pkg::SEL_CTRL;
      second_q <= 1'b0;
      dir_q <= 1'b0;
      wlatch_q <= 16'h0000;
      host_bus_o <= 16'h0000;
      host_bus_oe_o <= 1'b0;
      host_access_ready_o <= 1'b1;
      host_irq_out_n_o <= 1'b1;
      irq_o <= 1'b0;
      first_high_q <= hpp_pkg::FIRST_HIGH_RST;
      host_irq_q <= 1'b0;
      addr_q <= hpp_pkg::WORD_RST;
      addr_stage_q <= hpp_pkg::WORD_RST;
      wword_q <= hpp_pkg::WORD_RST;
      wdata_q <= hpp_pkg::WORD_RST;
      rdata_q <= hpp_pkg::WORD_RST;
      wfull_q <= 1'b0;
      rvalid_q <= 1'b0;
      status_q <= hpp_pkg::STATUS_RST;
      mask_q <= hpp_pkg::MASK_RST;
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
      strap_o <= '{endian: hpp_pkg::ENDIAN_BIG, boot: hpp_pkg::BOOT_HOST};
    end else begin
      state_q <= state_d;
      sel_q <= sel_d;
      second_q <= second_d;
      dir_q <= dir_d;
      wlatch_q <= wlatch_d;
      host_bus_o <= bus_d;
      host_bus_oe_o <= oe_d;
      host_access_ready_o <= ready_d;
      host_irq_out_n_o <= hirq_n_d;
      irq_o <= irq_d;
      first_high_q <= first_high_d;
      host_irq_q <= host_irq_d;
      addr_q <= addr_d;
      addr_stage_q <= addr_stage_d;
      wword_q <= wword_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      wfull_q <= wfull_d;
      rvalid_q <= rvalid_d;
      status_q <= status_d;
      mask_q <= mask_d;
      strap_cnt_q <= strap_cnt_d;
      strap_done_q <= strap_done_d;
      strap_o <= strap_d;
    end
  end
endmodule // hpp_top

// ### shared/hpp_pkg.sv
// Constants, types and helpers shared by the host port block
package hpp_pkg;

  localparam int unsigned AXI_AW = 8;

  // Register byte offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MASK = 8'h04;
  localparam logic [7:0] REG_STRAP = 8'h08;
  localparam logic [7:0] REG_HADDR = 8'h0c;
  localparam logic [7:0] REG_HWDATA = 8'h10;
  localparam logic [7:0] REG_HRDATA = 8'h14;
  localparam logic [7:0] REG_CTRL = 8'h18;

  // Status and mask bit positions
  localparam int unsigned ST_WDATA = 0;
  localparam int unsigned ST_DOORBELL = 1;
  localparam int unsigned ST_RDONE = 2;
  localparam int unsigned ST_W = 3;

  // Host-side control word bit positions
  localparam int unsigned HC_FIRST_HIGH = 0;
  localparam int unsigned HC_DOORBELL = 1;
  localparam int unsigned HC_IRQ = 2;

  // Software control register bit positions
  localparam int unsigned CR_IRQ_SET = 0;
  localparam int unsigned CR_FIRST_HIGH = 1;

  // Strap register field positions
  localparam int unsigned SR_ENDIAN = 0;
  localparam int unsigned SR_BOOT_LO = 1;

  // Strap pin positions on the host bus
  localparam int unsigned STRAP_ENDIAN_BIT = 8;
  localparam int unsigned STRAP_BOOT_HI = 4;
  localparam int unsigned STRAP_BOOT_LO = 3;

  // Reset values
  localparam logic [ST_W-1:0] STATUS_RST = 3'h0;
  localparam logic [ST_W-1:0] MASK_RST = 3'h0;
  localparam logic FIRST_HIGH_RST = 1'b0;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // Timing counts in core clock cycles
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
  localparam logic DIR_READ = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SEL_CTRL = 2'b00,
    SEL_ADDR = 2'b01,
    SEL_DATA_INC = 2'b10,
    SEL_DATA = 2'b11
  } hpp_sel_e;

  typedef enum logic {
    ENDIAN_BIG = 1'b0,
    ENDIAN_LITTLE = 1'b1
  } hpp_endian_e;

  typedef enum logic [1:0] {
    BOOT_HOST = 2'b00,
    BOOT_ROM8 = 2'b01,
    BOOT_ROM16 = 2'b10,
    BOOT_ROM32 = 2'b11
  } hpp_boot_e;

  typedef struct packed {
    logic cs_n;
    logic strobe_n;
    hpp_sel_e sel;
    logic second;
    logic dir;
    logic [15:0] bus;
  } hpp_pins_s;

  localparam hpp_pins_s PINS_IDLE = '{cs_n: 1'b1, strobe_n: 1'b1, sel: SEL_CTRL, second: 1'b0,
                                      dir: 1'b0, bus: 16'h0000};

  typedef struct packed {
    hpp_endian_e endian;
    hpp_boot_e boot;
  } hpp_strap_s;

  typedef struct packed {
    logic en;
    logic [AXI_AW-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } hpp_wr_s;

  function automatic logic reg_mapped(input logic [AXI_AW-1:0] addr);
    return addr inside {REG_STATUS, REG_MASK, REG_STRAP, REG_HADDR, REG_HWDATA, REG_HRDATA, REG_CTRL};
  endfunction

  // High half travels first when first_high is set
  function automatic logic use_high(input logic second, input logic first_high);
    return second ^ first_high;
  endfunction

  function automatic logic [15:0] pick_half(input logic [31:0] w, input logic second, input logic first_high);
    return use_high(second, first_high) ? w[31:16] : w[15:0];
  endfunction

  function automatic logic [31:0] put_half(input logic [31:0] w, input logic [15:0] h, input logic second,
                                           input logic first_high);
    return use_high(second, first_high) ? {h, w[15:0]} : {w[31:16], h};
  endfunction

  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

endpackage

// ### design/hpp_sync.sv
// Two flip-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
module hpp_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // hpp_sync

// ### design/hpp_axil.sv
// AXI4-Lite slave front end producing register strobes
`timescale 1ns/10ps
module hpp_axil (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [hpp_pkg::AXI_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [hpp_pkg::AXI_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output hpp_pkg::hpp_wr_s wr_o,
  output logic rd_en_o,
  input wire logic [31:0] rd_data_i
);
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [hpp_pkg::AXI_AW-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic fire_w;

  assign fire_w = aw_full_q && w_full_q && !s_axi_bvalid_o;
  assign rd_en_o = s_axi_arvalid_i && s_axi_arready_o;
  assign wr_o = '{en: fire_w, addr: awaddr_q, data: wdata_q, strb: wstrb_q};

  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = s_axi_bvalid_o;
    bresp_d = s_axi_bresp_o;
    rvalid_d = s_axi_rvalid_o;
    rresp_d = s_axi_rresp_o;
    rdata_d = s_axi_rdata_o;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_full_d = 1'b1;
      awaddr_d = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_full_d = 1'b1;
      wdata_d = s_axi_wdata_i;
      wstrb_d = s_axi_wstrb_i;
    end
    if (s_axi_bvalid_o && s_axi_bready_i) begin
      bvalid_d = 1'b0;
    end
    if (fire_w) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = hpp_pkg::reg_mapped(awaddr_q) ? hpp_pkg::RESP_OKAY : hpp_pkg::RESP_SLVERR;
    end
    if (s_axi_rvalid_o && s_axi_rready_i) begin
      rvalid_d = 1'b0;
    end
    if (rd_en_o) begin
      rvalid_d = 1'b1;
      rdata_d = rd_data_i;
      rresp_d = hpp_pkg::reg_mapped(s_axi_araddr_i) ? hpp_pkg::RESP_OKAY : hpp_pkg::RESP_SLVERR;
    end
    awready_d = !aw_full_d && !bvalid_d;
    wready_d = !w_full_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= hpp_pkg::WORD_RST;
      wstrb_q <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= hpp_pkg::RESP_OKAY;
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o <= hpp_pkg::RESP_OKAY;
      s_axi_rdata_o <= hpp_pkg::WORD_RST;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      s_axi_awready_o <= awready_d;
      s_axi_wready_o <= wready_d;
      s_axi_bvalid_o <= bvalid_d;
      s_axi_bresp_o <= bresp_d;
      s_axi_arready_o <= arready_d;
      s_axi_rvalid_o <= rvalid_d;
      s_axi_rresp_o <= rresp_d;
      s_axi_rdata_o <= rdata_d;
    end
  end
endmodule // hpp_axil

// ### testbench/hpp_top_chk.sv
// Concurrent checks on the host port block
`timescale 1ns/10ps
module hpp_top_chk (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic host_cs_n_i,
  input wire logic host_strobe_n_i,
  input wire logic host_direction_i,
  input wire logic [15:0] host_bus_i,
  input wire logic [15:0] host_bus_o,
  input wire logic host_bus_oe_o,
  input wire hpp_pkg::hpp_strap_s strap_o,
  input wire logic [hpp_pkg::AXI_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o
);
  logic [2:0] cnt_q, cnt_d;
  logic [15:0] snap_q, snap_d;
  logic rd_acc;
  assign rd_acc = !host_cs_n_i && !host_strobe_n_i && host_direction_i;
  // Edges since reset release
  always_comb begin
    cnt_d = (cnt_q == 3'h7) ? cnt_q : cnt_q + 3'h1;
    snap_d = (cnt_q == 3'h1) ? host_bus_i : snap_q;
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 3'h0;
      snap_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
      snap_q <= snap_d;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_strap_capture: assert property (cnt_q == 3'h6 |-> strap_o == {snap_q[8], snap_q[4:3]})
    else $error("strap capture wrong");
  a_strap_hold: assert property (cnt_q == 3'h7 |-> $stable(strap_o))
    else $error("strap moved");
  a_oe_read_only: assert property ($rose(host_bus_oe_o) |-> $past(rd_acc, 3))
    else $error("bus driven without read");
  a_oe_release: assert property ($rose(host_strobe_n_i) && host_bus_oe_o |-> ##[1:4] !host_bus_oe_o)
    else $error("bus held after strobe");
  a_bus_quiet: assert property (!host_bus_oe_o |-> host_bus_o == 16'h0000)
    else $error("bus not quiet");
  a_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_ar_busy: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while busy");
  a_rd_refuse: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i > hpp_pkg::REG_CTRL
    |=> s_axi_rresp_o == hpp_pkg::RESP_SLVERR && s_axi_rdata_o == 32'h0000_0000)
    else $error("unmapped read accepted");
  c_host_read: cover property ($rose(host_bus_oe_o));
  c_axi_read: cover property ($rose(s_axi_rvalid_o));
  c_strap: cover property (cnt_q == 3'h6);
endmodule // hpp_top_chk

bind hpp_top hpp_top_chk chk_u (.core_clk_i, .rst_n_i, .host_cs_n_i, .host_strobe_n_i, .host_direction_i,
  .host_bus_i, .host_bus_o, .host_bus_oe_o, .strap_o, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o);

// ### testbench/hpp_host_model.sv
// Behavioural external host driving the host port pins
`timescale 1ns/10ps
module hpp_host_model (
  input wire logic core_clk_i,
  input wire logic [15:0] host_bus_o,
  input wire logic host_bus_oe_o,
  input wire logic host_access_ready_o,
  input wire logic [15:0] pull_i,
  output hpp_pkg::hpp_pins_s pins_o,
  output logic [15:0] host_bus_i
);
  logic drive = 1'b0;
  initial pins_o = hpp_pkg::PINS_IDLE;
  // Wire level: device, else host, else the pull resistors
  assign host_bus_i = host_bus_oe_o ? host_bus_o : (drive ? pins_o.bus : pull_i);
  task automatic access(input hpp_pkg::hpp_sel_e sel, input logic second, input logic dir,
                        input logic [15:0] wd, output logic [15:0] rd, output logic ok);
    int n;
    @(posedge core_clk_i);
    pins_o <= '{cs_n: 1'b0, strobe_n: 1'b0, sel: sel, second: second, dir: dir, bus: wd};
    drive <= !dir;
    n = 0;
    repeat (4) @(posedge core_clk_i);
    while (!host_access_ready_o && n < 16) begin
      @(posedge core_clk_i);
      n++;
    end
    ok = host_access_ready_o;
    rd = host_bus_i;
    pins_o.cs_n <= 1'b1;
    pins_o.strobe_n <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    drive <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask
endmodule // hpp_host_model

// ### testbench/tb_host_port_pins_and_boot_straps.sv
// Self-checking testbench for the host port block
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_host_port_pins_and_boot_straps;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  hpp_pkg::hpp_pins_s pins;
  hpp_pkg::hpp_strap_s strap;
  logic [15:0] hbus, bus_o, rd16;
  logic [15:0] pull = 16'hffef;
  logic oe, hirq_n, rdy, irq, awr, wr, bv, arr, rv, ok;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd32;
  logic [1:0] bresp, rresp, resp;
  int n_fail = 0;
  int num_checks = 0;
  always #5 core_clk_i = ~core_clk_i;
  hpp_top dut_u (.core_clk_i, .rst_n_i, .host_cs_n_i(pins.cs_n), .host_strobe_n_i(pins.strobe_n),
    .host_reg_select_hi_i(pins.sel[1]), .host_reg_select_lo_i(pins.sel[0]), .host_halfword_order_i(pins.second),
    .host_direction_i(pins.dir), .host_bus_i(hbus), .host_bus_o(bus_o), .host_bus_oe_o(oe), .host_irq_out_n_o(hirq_n),
    .host_access_ready_o(rdy), .strap_o(strap), .irq_o(irq), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rready));
  hpp_host_model host_u (.core_clk_i, .host_bus_o(bus_o), .host_bus_oe_o(oe), .host_access_ready_o(rdy),
    .pull_i(pull), .pins_o(pins), .host_bus_i(hbus));
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    @(posedge core_clk_i);
    while (bready) begin
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) `CHK(bresp, hpp_pkg::RESP_OKAY)
      if (bv) bready <= 1'b0;
      @(posedge core_clk_i);
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk_i);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    @(posedge core_clk_i);
    while (rready) begin
      if (arr) arv <= 1'b0;
      if (rv) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
      @(posedge core_clk_i);
    end
  endtask
  task automatic hwr32(input hpp_pkg::hpp_sel_e sel, input logic fh, input logic [31:0] w);
    host_u.access(sel, 1'b0, 1'b0, fh ? w[31:16] : w[15:0], rd16, ok);
    host_u.access(sel, 1'b1, 1'b0, fh ? w[15:0] : w[31:16], rd16, ok);
    `CHK(ok, 1'b1)
  endtask
  task automatic t_straps;
    logic [15:0] p;
    for (int i = 0; i < 4; i++) begin
      p = 16'hffef;
      p[8] = ~i[0];
      p[4:3] = i[1:0];
      rst_n_i <= 1'b0;
      pull <= p;
      repeat (10) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      `CHK(strap, {p[8], p[4:3]})
      axi_rd(hpp_pkg::REG_STRAP, rd32, resp);
      `CHK(rd32, {29'h0, p[4:3], p[8]})
      pull <= ~p;
      repeat (4) @(posedge core_clk_i);
      `CHK(strap, {p[8], p[4:3]})
    end
  endtask
  task automatic t_write;
    axi_wr(hpp_pkg::REG_MASK, 32'h0000_0007);
    for (int fh = 1; fh >= 0; fh--) begin
      host_u.access(hpp_pkg::SEL_CTRL, 1'b0, 1'b0, {15'h0, fh[0]}, rd16, ok);
      hwr32(hpp_pkg::SEL_DATA, fh[0], 32'h1234_abcd ^ {32{fh[0]}});
      axi_rd(hpp_pkg::REG_HWDATA, rd32, resp);
      `CHK(rd32, 32'h1234_abcd ^ {32{fh[0]}})
      `CHK(irq, 1'b1)
      axi_wr(hpp_pkg::REG_STATUS, 32'h0000_0007);
      repeat (2) @(posedge core_clk_i);
      `CHK(irq, 1'b0)
    end
  endtask
  task automatic t_read;
    hwr32(hpp_pkg::SEL_ADDR, 1'b0, 32'h0000_0100);
    axi_rd(hpp_pkg::REG_HADDR, rd32, resp);
    `CHK(rd32, 32'h0000_0100)
    axi_wr(hpp_pkg::REG_HRDATA, 32'hcafe_0123);
    host_u.access(hpp_pkg::SEL_DATA_INC, 1'b0, 1'b1, 16'h0000, rd16, ok);
    `CHK(rd16, 16'h0123)
    host_u.access(hpp_pkg::SEL_DATA_INC, 1'b1, 1'b1, 16'h0000, rd16, ok);
    `CHK(rd16, 16'hcafe)
    axi_rd(hpp_pkg::REG_HADDR, rd32, resp);
    `CHK(rd32, 32'h0000_0104)
    host_u.access(hpp_pkg::SEL_DATA, 1'b0, 1'b1, 16'h0000, rd16, ok);
    `CHK(ok, 1'b0)
    axi_rd(8'h1c, rd32, resp);
    `CHK(resp, hpp_pkg::RESP_SLVERR)
  endtask
  task automatic t_hirq;
    axi_wr(hpp_pkg::REG_STATUS, 32'h0000_0007);
    axi_wr(hpp_pkg::REG_CTRL, 32'h0000_0001);
    repeat (2) @(posedge core_clk_i);
    `CHK(hirq_n, 1'b0)
    host_u.access(hpp_pkg::SEL_CTRL, 1'b0, 1'b1, 16'h0000, rd16, ok);
    `CHK(rd16, 16'h0004)
    host_u.access(hpp_pkg::SEL_CTRL, 1'b0, 1'b0, 16'h0006, rd16, ok);
    `CHK(hirq_n, 1'b1)
    axi_rd(hpp_pkg::REG_STATUS, rd32, resp);
    `CHK(rd32, 32'h0000_0002)
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    t_straps;
    t_write;
    t_read;
    t_hirq;
    final_report;
  end
  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_fail++;
    final_report;
  end
endmodule // tb_host_port_pins_and_boot_straps
